// ### rtl/spc_pkg.sv
// Purpose: Shared constants and types for the serial port pin configuration block.
// Assumes: Three pins: serial clock pin, serial data I/O pin, serial data output pin.
// Notes: Pin bit index 0, 1 and 2 is used on every per-pin port vector.
package spc_pkg;

   // Output driver type selected for one pin.
   typedef enum logic [1:0] {
      SPC_DRV_OPEN = 2'b00, // Driver off, pin floats.
      SPC_DRV_CMOS = 2'b01, // Push-pull drive, fast edges.
      SPC_DRV_SLOW = 2'b10, // Push-pull drive, slow edges.
      SPC_DRV_NOD = 2'b11 // N-channel open drain.
   } spc_drive_t;

   // Number of pins handled and their bit positions.
   localparam int SPC_PINS = 3;
   localparam int SPC_CLK_IDX = 0;
   localparam int SPC_DIO_IDX = 1;
   localparam int SPC_DOUT_IDX = 2;

   // Codes of {second select, latch, direction} when the peripheral is selected.
   localparam logic [2:0] SPC_CFG_CMOS = 3'h1;
   localparam logic [2:0] SPC_CFG_SLOW = 3'h6;
   localparam logic [2:0] SPC_CFG_NOD = 3'h5;
   localparam logic [2:0] SPC_CFG_OPEN = 3'h7;

   // Widths of the synchroniser banks in each clock domain.
   localparam int SPC_SYNC_W_SYS = 5;
   localparam int SPC_SYNC_W_LINK = 3;

   // Reset values of pin outputs and flags.
   localparam logic SPC_PIN_RST = 1'b0;
   localparam logic SPC_FLAG_RST = 1'b0;

endpackage : spc_pkg

// ### rtl/spc_sync3.sv
// Purpose: Three-stage synchroniser bank with agreement filter.
// Assumes: Inputs come from outside the clk domain.
// Notes: The first stage feeds only the second; a change counts when stages two and three agree.
`timescale 1ns/1ps
module spc_sync3 import spc_pkg::*; #(
   parameter int W = 1 // Number of bits synchronised.
) (
   input wire logic clk, // Destination clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable, freezes all state while low.
   input wire logic [W-1:0] d, // Asynchronous inputs.
   output logic [W-1:0] q // Filtered synchronised outputs.
);

   logic [W-1:0] s1_reg; // First stage, read only by the second.
   logic [W-1:0] s2_reg; // Second stage.
   logic [W-1:0] s3_reg; // Third stage.

   // Shift the inputs through the three stages.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else if (ce) begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Accept a new value per bit only when stages two and three agree.
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               q[i] <= 1'b0;
            end else if (ce && (s2_reg[i] == s3_reg[i])) begin
               q[i] <= s3_reg[i];
            end
         end
      end
   endgenerate

endmodule : spc_sync3

// ### rtl/spc_cond_det.sv
// Purpose: Start and stop condition detector on the two-wire bus.
// Assumes: Runs on the link clock with synchronised bus levels.
// Notes: Each detected condition flips a toggle so the event can cross clock domains.
`timescale 1ns/1ps
module spc_cond_det import spc_pkg::*; (
   input wire logic link_clk, // Link sampling clock.
   input wire logic link_rst_n, // Link-domain reset, active low.
   input wire logic ce, // Clock enable in the link domain.
   input wire logic scl, // Synchronised clock line level.
   input wire logic sda, // Synchronised data line level.
   output logic start_tgl, // Flips on each start condition.
   output logic stop_tgl // Flips on each stop condition.
);

   logic scl_prev_reg; // Clock line one sample ago.
   logic sda_prev_reg; // Data line one sample ago.
   logic start_hit; // Data fell while clock stayed high.
   logic stop_hit; // Data rose while clock stayed high.

   assign start_hit = scl && scl_prev_reg && sda_prev_reg && !sda;
   assign stop_hit = scl && scl_prev_reg && !sda_prev_reg && sda;

   // Keep the previous line levels for edge comparison.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         scl_prev_reg <= 1'b0;
         sda_prev_reg <= 1'b0;
      end else if (ce) begin
         scl_prev_reg <= scl;
         sda_prev_reg <= sda;
      end
   end

   // Flip a toggle for every start or stop seen.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         start_tgl <= SPC_FLAG_RST;
         stop_tgl <= SPC_FLAG_RST;
      end else if (ce) begin
         if (start_hit) begin
            start_tgl <= !start_tgl;
         end
         if (stop_hit) begin
            stop_tgl <= !stop_tgl;
         end
      end
   end

   start_flip_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (ce && scl && scl_prev_reg && sda_prev_reg && !sda) |=> (start_tgl != $past(start_tgl)))
      else $error("Start condition not flagged.");

   stop_flip_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (ce && scl && scl_prev_reg && !sda_prev_reg && sda) |=> (stop_tgl != $past(stop_tgl)))
      else $error("Stop condition not flagged.");

endmodule : spc_cond_det

// ### rtl/spc_pin_config.sv
// Purpose: Pin configuration between the combined serial unit and its three port pins.
// Assumes: clk is the 125 MHz system clock; link_clk samples the two-wire bus.
// Notes: Pin vectors use bit 0 clock pin, bit 1 data I/O pin, bit 2 data output pin.
`timescale 1ns/1ps
module spc_pin_config import spc_pkg::*; (
   input wire logic clk, // System clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable, freezes all system-domain state and the condition detector while low.
   input wire logic link_clk, // Bus sampling clock of the link domain.
   input wire logic [2:0] port_a_function_select_first, // First function select per pin.
   input wire logic [2:0] port_a_function_select_second, // Second function select per pin.
   input wire logic [2:0] port_a_output_latch, // Port latch per pin.
   input wire logic [2:0] port_a_direction, // Direction bit per pin.
   input wire logic iic_port_level_control, // Two-wire port level enable.
   input wire logic iic_port_slew_select, // Slow edges on open-drain pins.
   input wire logic sio_clk_out, // Serial unit clock output.
   input wire logic sio_data_out, // Serial unit data output.
   input wire logic [2:0] pin_in, // Pin levels from the pads.
   output logic [2:0] pin_out, // Pin output values.
   output logic [2:0] pin_oe, // Pin output enables, high while driving.
   output logic [2:0] pin_slow, // Slow edge select per pad.
   output logic rx_clk, // Synchronised clock pin level to the serial unit.
   output logic rx_data, // Synchronised data pin level to the serial unit.
   output logic start_seen, // One-cycle pulse per start condition.
   output logic stop_seen, // One-cycle pulse per stop condition.
   output logic iic_ready // Pins set up for two-wire use.
);

   // Maps the select, latch and direction bits of one pin to its driver type.
   // Any code that is not listed for a selected pin leaves the pin open,
   // so a half-written setup never fights the far side.
   function automatic spc_drive_t drive_mode(input logic fsa, input logic fsb,
                                             input logic lat, input logic ddr);
      spc_drive_t m;
      m = SPC_DRV_OPEN;
      if (!fsa) begin
         // General port: drive the latch in push-pull when set as output.
         m = ddr ? SPC_DRV_CMOS : SPC_DRV_OPEN;
      end else begin
         case ({fsb, lat, ddr})
            SPC_CFG_CMOS: m = SPC_DRV_CMOS;
            SPC_CFG_SLOW: m = SPC_DRV_SLOW;
            SPC_CFG_NOD: m = SPC_DRV_NOD;
            SPC_CFG_OPEN: m = SPC_DRV_OPEN;
            default: m = SPC_DRV_OPEN;
         endcase
      end
      return m;
   endfunction : drive_mode

   // Link domain signals.
   logic link_rst1_reg; // Link reset synchroniser, first stage.
   logic link_rst_n; // Link reset, released on link_clk.
   logic [SPC_SYNC_W_LINK-1:0] link_sync; // Clock line, data line and enable in link domain.
   logic start_tgl; // Start event toggle.
   logic stop_tgl; // Stop event toggle.

   // System domain signals.
   logic [SPC_SYNC_W_SYS-1:0] sys_sync; // Pins and event toggles in system domain.
   logic start_tgl_prev_reg; // Previous start toggle.
   logic stop_tgl_prev_reg; // Previous stop toggle.
   logic scl_level; // Synchronised clock pin level.
   logic sda_level; // Synchronised data pin level.
   logic sda_hold; // Data drive must stay put.
   spc_drive_t mode [SPC_PINS]; // Driver type per pin.
   logic [2:0] src; // Value each pin should present.
   logic [2:0] val_next; // Next held drive value.
   logic [2:0] val_reg; // Held drive value per pin.

   // Release the link reset on the link clock; assertion is immediate.
   // Release is synchronised so no link flop leaves reset on a stray edge.
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         link_rst1_reg <= 1'b0;
         link_rst_n <= 1'b0;
      end else begin
         link_rst1_reg <= 1'b1;
         link_rst_n <= link_rst1_reg;
      end
   end

   // Bring both bus lines and the enable into the link domain.
   // The link side runs without the clock enable; the enable itself crosses over.
   spc_sync3 #(.W(SPC_SYNC_W_LINK)) u_link_sync (
      .clk(link_clk),
      .reset_n(link_rst_n),
      .ce(1'b1),
      .d({ce, pin_in[SPC_DIO_IDX], pin_in[SPC_CLK_IDX]}),
      .q(link_sync)
   );

   // Watch the bus for start and stop conditions.
   // Its enable is the synchronised clock enable, so it freezes with the rest.
   spc_cond_det u_cond_det (
      .link_clk(link_clk),
      .link_rst_n(link_rst_n),
      .ce(link_sync[2]),
      .scl(link_sync[0]),
      .sda(link_sync[1]),
      .start_tgl(start_tgl),
      .stop_tgl(stop_tgl)
   );

   // Bring pin levels and event toggles into the system domain.
   // Each toggle changes once per event, so a bit by bit crossing is safe.
   spc_sync3 #(.W(SPC_SYNC_W_SYS)) u_sys_sync (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .d({stop_tgl, start_tgl, pin_in}),
      .q(sys_sync)
   );

   assign scl_level = sys_sync[SPC_CLK_IDX];
   assign sda_level = sys_sync[SPC_DIO_IDX];

   // Data pin always has its receive input on, whatever the output type.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_clk <= SPC_PIN_RST;
         rx_data <= SPC_PIN_RST;
      end else if (ce) begin
         rx_clk <= scl_level;
         rx_data <= sda_level;
      end
   end

   // Turn event toggles back into one-cycle pulses.
   // Two events closer than the crossing delay may merge into one pulse.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         start_tgl_prev_reg <= SPC_FLAG_RST;
         stop_tgl_prev_reg <= SPC_FLAG_RST;
         start_seen <= SPC_FLAG_RST;
         stop_seen <= SPC_FLAG_RST;
      end else if (ce) begin
         start_tgl_prev_reg <= sys_sync[3];
         stop_tgl_prev_reg <= sys_sync[4];
         start_seen <= sys_sync[3] ^ start_tgl_prev_reg;
         stop_seen <= sys_sync[4] ^ stop_tgl_prev_reg;
      end
   end

   // With the level bit on, the open-drain data line is frozen while the clock line is high,
   // so the device never forms a false start or stop itself.
   // Pins in other modes are never held, so plain serial data is not delayed.
   assign sda_hold = iic_port_level_control && (mode[SPC_DIO_IDX] == SPC_DRV_NOD)
                     && scl_level;

   // Decode driver type and source per pin.
   // Each pin gets its own decode, source select and output registers.
   genvar i;
   generate
      for (i = 0; i < SPC_PINS; i++) begin : g_pin
         assign mode[i] = drive_mode(port_a_function_select_first[i],
                                     port_a_function_select_second[i],
                                     port_a_output_latch[i], port_a_direction[i]);
         if (i == SPC_CLK_IDX) begin : g_clk_src
            // Clock pin carries the serial clock when the peripheral owns it.
            assign src[i] = port_a_function_select_first[i] ? sio_clk_out
                            : port_a_output_latch[i];
         end else begin : g_data_src
            // Both data pins carry the serial data when the peripheral owns them.
            assign src[i] = port_a_function_select_first[i] ? sio_data_out
                            : port_a_output_latch[i];
         end
         if (i == SPC_DIO_IDX) begin : g_hold
            assign val_next[i] = sda_hold ? val_reg[i] : src[i];
         end else begin : g_free
            assign val_next[i] = src[i];
         end

         // Keep the value that was last presented on this pin.
         // The held copy is what the data hold replays while the clock line is high.
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               val_reg[i] <= SPC_PIN_RST;
            end else if (ce) begin
               val_reg[i] <= val_next[i];
            end
         end

         // Drive the pad according to the selected driver type.
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               pin_out[i] <= SPC_PIN_RST;
               pin_oe[i] <= SPC_PIN_RST;
               pin_slow[i] <= SPC_PIN_RST;
            end else if (ce) begin
               unique case (mode[i])
                  SPC_DRV_OPEN: begin
                     // Output stays off; only the input path works.
                     pin_out[i] <= 1'b0;
                     pin_oe[i] <= 1'b0;
                     pin_slow[i] <= 1'b0;
                  end
                  SPC_DRV_CMOS: begin
                     // Push-pull drive with fast edges.
                     pin_out[i] <= val_next[i];
                     pin_oe[i] <= 1'b1;
                     pin_slow[i] <= 1'b0;
                  end
                  SPC_DRV_SLOW: begin
                     // Push-pull drive with slow edges.
                     pin_out[i] <= val_next[i];
                     pin_oe[i] <= 1'b1;
                     pin_slow[i] <= 1'b1;
                  end
                  SPC_DRV_NOD: begin
                     // Pull low for a zero, release for a one.
                     // The pull-up on the far side supplies the high level.
                     pin_out[i] <= 1'b0;
                     pin_oe[i] <= !val_next[i];
                     pin_slow[i] <= iic_port_slew_select;
                  end
               endcase
            end
         end
      end
   endgenerate

   // Report when both bus pins are set up as open drain with the level bit on.
   // The flag only reports the setup; it does not gate the drive logic.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         iic_ready <= SPC_FLAG_RST;
      end else if (ce) begin
         iic_ready <= iic_port_level_control && (mode[SPC_CLK_IDX] == SPC_DRV_NOD)
                      && (mode[SPC_DIO_IDX] == SPC_DRV_NOD);
      end
   end

   // Drive decode checks: each looks one edge after the setup is taken,
   // when the output registers hold the new value.
   dio_cmos_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && port_a_function_select_first[1]
       && ({port_a_function_select_second[1], port_a_output_latch[1],
            port_a_direction[1]} == SPC_CFG_CMOS) && !sda_hold)
      |=> (pin_oe[1] && (pin_out[1] == $past(sio_data_out)) && !pin_slow[1]))
      else $error("Data pin push-pull drive wrong.");

   dio_open_drain_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && port_a_function_select_first[1]
       && ({port_a_function_select_second[1], port_a_output_latch[1],
            port_a_direction[1]} == SPC_CFG_NOD))
      |=> (!pin_out[1] && (pin_oe[1] == !$past(val_next[1]))))
      else $error("Data pin open drain drive wrong.");

   dio_slow_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && port_a_function_select_first[1]
       && ({port_a_function_select_second[1], port_a_output_latch[1],
            port_a_direction[1]} == SPC_CFG_SLOW))
      |=> (pin_oe[1] && pin_slow[1] && (pin_out[1] == $past(sio_data_out))))
      else $error("Data pin slow drive wrong.");

   dout_cmos_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && port_a_function_select_first[2]
       && ({port_a_function_select_second[2], port_a_output_latch[2],
            port_a_direction[2]} == SPC_CFG_CMOS))
      |=> (pin_oe[2] && (pin_out[2] == $past(sio_data_out))))
      else $error("Data output pin push-pull drive wrong.");

   dout_slow_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && port_a_function_select_first[2]
       && ({port_a_function_select_second[2], port_a_output_latch[2],
            port_a_direction[2]} == SPC_CFG_SLOW))
      |=> (pin_oe[2] && pin_slow[2] && (pin_out[2] == $past(sio_data_out))))
      else $error("Data output pin slow drive wrong.");

   dout_od_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && port_a_function_select_first[2]
       && ({port_a_function_select_second[2], port_a_output_latch[2],
            port_a_direction[2]} == SPC_CFG_NOD))
      |=> (!pin_out[2] && (pin_oe[2] == !$past(sio_data_out))))
      else $error("Data output pin open drain drive wrong.");

   clk_pin_open_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && (port_a_function_select_first[0] && port_a_function_select_second[0]
              && port_a_output_latch[0] && port_a_direction[0]))
      |=> !pin_oe[0])
      else $error("Clock pin driven while set open.");

   clk_pin_od_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && port_a_function_select_first[0]
       && ({port_a_function_select_second[0], port_a_output_latch[0],
            port_a_direction[0]} == SPC_CFG_NOD) && !sio_clk_out)
      |=> (pin_oe[0] && !pin_out[0]))
      else $error("Clock pin not pulled low.");

   port_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && !port_a_function_select_first[2] && port_a_direction[2])
      |=> (pin_oe[2] && (pin_out[2] == $past(port_a_output_latch[2]))))
      else $error("General port does not drive latch.");

   sda_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ce && sda_hold) |=> (val_reg[1] == $past(val_reg[1])))
      else $error("Data line changed while clock high.");

endmodule : spc_pin_config

// ### verification/spc_bus_model.sv
// Purpose: Far-side model of the serial and two-wire bus devices at the three pins.
// Assumes: Every line has a pull-up; the far devices only ever pull a line low.
// Notes: Line levels resolve the design's enables against the model's own pulls.
`timescale 1ns/1ps
module spc_bus_model (
   input wire logic link_clk, // Pacing clock for bus phases.
   input wire logic [2:0] pin_out, // Design pin values.
   input wire logic [2:0] pin_oe, // Design pin enables, high while driving.
   output logic [2:0] pin_in // Resolved line levels back to the pads.
);
   logic scl_pull; // Model pulls the clock line low.
   logic sda_pull; // Model pulls the data line low.

   // Both lines start released.
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // A line is the driven value while enabled, else the pull-up level, and low when pulled.
   always_comb begin
      pin_in[0] = (pin_oe[0] ? pin_out[0] : 1'b1) & ~scl_pull;
      pin_in[1] = (pin_oe[1] ? pin_out[1] : 1'b1) & ~sda_pull;
      pin_in[2] = pin_oe[2] ? pin_out[2] : 1'b1;
   end

   // Sets both pulls at once, then holds them until four rising link edges have passed.
   task automatic set_pulls(input logic scl_low, input logic sda_low);
      scl_pull = scl_low;
      sda_pull = sda_low;
      repeat (4) @(posedge link_clk);
   endtask : set_pulls

   // Start: the data line falls while the clock line is high, then the clock goes low.
   task automatic start_cond();
      set_pulls(1'b0, 1'b0);
      set_pulls(1'b0, 1'b1);
      set_pulls(1'b1, 1'b1);
   endtask : start_cond

   // Stop: the clock rises with data low, then data is released while the clock is high.
   task automatic stop_cond();
      set_pulls(1'b1, 1'b1);
      set_pulls(1'b0, 1'b1);
      set_pulls(1'b0, 1'b0);
   endtask : stop_cond

   // Ordinary data movement: data changes only while the clock line is low.
   task automatic data_while_low();
      set_pulls(1'b1, 1'b0);
      set_pulls(1'b1, 1'b1);
      set_pulls(1'b1, 1'b0);
      set_pulls(1'b0, 1'b0);
   endtask : data_while_low
endmodule : spc_bus_model

// ### verification/tb_spc_pin_config.sv
// Purpose: Self-checking bench for the serial port pin configuration block.
// Assumes: Far-side devices are modelled by spc_bus_model with pull-ups on the lines.
// Notes: Expected drive values are worked out here from the mode table, not from the design.
`timescale 1ns/1ps
module tb_spc_pin_config import spc_pkg::*;;
   logic clk, reset_n, ce, link_clk; // Clocks, reset and enable.
   logic [2:0] fsa, fsb, lat, ddr; // Per-pin mode bits.
   logic lvl, slew, sclk_o, sdat_o; // Two-wire controls and serial unit outputs.
   logic [2:0] pin_in, pin_out, pin_oe, pin_slow; // Pad side.
   logic rx_clk, rx_data, start_seen, stop_seen, iic_ready; // Design results.
   int err_total = 0; // Mismatches.
   int n_tests = 0; // Comparisons.
   int n_start = 0; // Start pulses seen.
   int n_stop = 0; // Stop pulses seen.

   spc_pin_config DUT (.clk(clk), .reset_n(reset_n), .ce(ce), .link_clk(link_clk),
      .port_a_function_select_first(fsa), .port_a_function_select_second(fsb),
      .port_a_output_latch(lat), .port_a_direction(ddr), .iic_port_level_control(lvl),
      .iic_port_slew_select(slew), .sio_clk_out(sclk_o), .sio_data_out(sdat_o),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_slow(pin_slow),
      .rx_clk(rx_clk), .rx_data(rx_data), .start_seen(start_seen), .stop_seen(stop_seen),
      .iic_ready(iic_ready));
   spc_bus_model u_bus (.link_clk(link_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));

   // System clock of 8 ns.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Link clock of 160 ns, offset so its edges never meet the system clock.
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #80 link_clk = ~link_clk;
   end
   // Counts the one-cycle condition pulses.
   always @(posedge clk) begin
      if (start_seen === 1'b1) n_start <= n_start + 1;
      if (stop_seen === 1'b1) n_stop <= n_stop + 1;
   end

   // Compares single bits.
   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk1
   // Compares per-pin vectors.
   task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk3
   // Compares event counts.
   task automatic chk_n(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         err_total++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_n
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // Lets n edges pass and steps clear of the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Puts one {first select, second select, latch, direction} code on all pins.
   task automatic set_all(input logic [3:0] c);
      fsa <= {3{c[3]}};
      fsb <= {3{c[2]}};
      lat <= {3{c[1]}};
      ddr <= {3{c[0]}};
   endtask : set_all
   // Expected {slow care, slow, out care, oe, out} for one pin.
   function automatic logic [4:0] exp_pin(input logic [3:0] c, input logic s, input logic w);
      if (!c[3]) return {2'b00, c[0], c[0], c[1]};
      case (c[2:0])
         3'h1: return {2'b10, 2'b11, s};
         3'h6: return {2'b11, 2'b11, s};
         3'h5: return {1'b1, w, 1'b1, ~s, 1'b0};
         default: return 5'h00;
      endcase
   endfunction : exp_pin

   // Outputs stay low through reset, then reset is released.
   task automatic t_reset();
      repeat (5) @(posedge clk);
      #1;
      chk3(pin_oe, 3'h0);
      chk3(pin_out, 3'h0);
      chk1(start_seen, 1'b0);
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      tick(4);
   endtask : t_reset
   // Eight mode codes covering all four driver types on every pin with both source values and both slew settings.
   task automatic t_modes();
      logic [3:0] codes [8];
      logic [4:0] e;
      codes = '{4'h9, 4'he, 4'hd, 4'hf, 4'h1, 4'h7, 4'h0, 4'hb};
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            set_all(codes[c]);
            sclk_o <= k[0];
            sdat_o <= k[0];
            slew <= k[1];
            tick(2);
            e = exp_pin(codes[c], k[0], k[1]);
            for (int p = 0; p < 3; p++) begin
               chk1(pin_oe[p], e[1]);
               if (e[2]) chk1(pin_out[p], e[0]);
               if (e[4]) chk1(pin_slow[p], e[3]);
            end
         end
      end
   endtask : t_modes
   // A change made while the enable is low waits until the enable returns.
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      set_all(4'h9);
      sclk_o <= 1'b1;
      sdat_o <= 1'b1;
      tick(3);
      chk3(pin_oe, 3'h0);
      @(posedge clk);
      ce <= 1'b1;
      tick(2);
      chk3(pin_oe, 3'h7);
      chk3(pin_out, 3'h7);
   endtask : t_freeze
   // External clock and data reach the serial unit with the pins open, then with the data pin set to push-pull low.
   task automatic t_rx();
      @(posedge clk);
      set_all(4'hf);
      for (int k = 0; k < 4; k++) begin
         u_bus.set_pulls(k[0], k[1]);
         chk1(rx_clk, ~k[0]);
         chk1(rx_data, ~k[1]);
      end
      @(posedge clk);
      fsb[1] <= 1'b0;
      lat[1] <= 1'b0;
      sdat_o <= 1'b0;
      tick(8);
      chk1(rx_data, 1'b0);
   endtask : t_rx
   // Two-wire setup, start, stop and ordinary data movement.
   task automatic t_iic();
      int o_start;
      int o_stop;
      @(posedge clk);
      set_all(4'hd);
      lvl <= 1'b1;
      slew <= 1'b0;
      sdat_o <= 1'b1;
      sclk_o <= 1'b1;
      tick(8);
      chk1(iic_ready, 1'b1);
      o_start = n_start;
      o_stop = n_stop;
      u_bus.start_cond();
      for (int i = 0; i < 300 && n_start == o_start; i++) tick(1);
      chk_n(n_start, o_start + 1);
      chk_n(n_stop, o_stop);
      u_bus.stop_cond();
      for (int i = 0; i < 300 && n_stop == o_stop; i++) tick(1);
      chk_n(n_stop, o_stop + 1);
      u_bus.data_while_low();
      tick(100);
      chk_n(n_start, o_start + 1);
      chk_n(n_stop, o_stop + 1);
   endtask : t_iic
   // The data pin holds its value while the clock line is high.
   task automatic t_hold();
      int o_start;
      o_start = n_start;
      @(posedge clk);
      sdat_o <= 1'b0;
      tick(4);
      chk1(pin_oe[1], 1'b0);
      u_bus.set_pulls(1'b1, 1'b0);
      chk1(pin_oe[1], 1'b1);
      chk1(pin_out[1], 1'b0);
      @(posedge clk);
      sdat_o <= 1'b1;
      tick(4);
      u_bus.set_pulls(1'b0, 1'b0);
      tick(60);
      chk_n(n_start, o_start);
      @(posedge clk);
      lvl <= 1'b0;
      tick(3);
      chk1(iic_ready, 1'b0);
   endtask : t_hold

   // Time-zero values, then the scenarios in order.
   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      fsa = 3'h0;
      fsb = 3'h0;
      lat = 3'h0;
      ddr = 3'h0;
      lvl = 1'b0;
      slew = 1'b0;
      sclk_o = 1'b0;
      sdat_o = 1'b0;
      t_reset();
      t_modes();
      t_freeze();
      t_rx();
      t_iic();
      t_hold();
      conclude();
   end
endmodule : tb_spc_pin_config
